// File: common/ppb_pkg.sv
// shared constants for the programming port boot link
package ppb_pkg;
	// timing
	localparam int CLK_HZ     = 100_000_000;
	localparam int BAUD_BPS   = 2400;
	localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
	// buffering
	localparam int BYTE_W     = 8;
	localparam int FIFO_DEPTH = 4;
	// apb register byte offsets
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_SERIAL_PORT_CONTROL_REG = 12'h004;
	localparam logic [11:0] ADDR_DATA = 12'h008;
	// control register fields
	localparam int CTRL_UART_EN = 0;
	localparam int CTRL_GPIO    = 1;
	localparam int CTRL_TX_GPIO = 2;
	localparam int CTRL_STATUS  = 3;
	localparam int CTRL_CLOCKED = 4;
	localparam int CTRL_COLD    = 5;
	// serial_port_control_reg fields
	localparam int SERIAL_PORT_CONTROL_REG_LO      = 0;
	localparam int SERIAL_PORT_CONTROL_REG_HI      = 1;
	localparam int SERIAL_PORT_CONTROL_REG_RX      = 2;
	localparam int SERIAL_PORT_CONTROL_REG_CLK     = 3;
	localparam int SERIAL_PORT_CONTROL_REG_CABLE   = 4;
	localparam int SERIAL_PORT_CONTROL_REG_AVAIL   = 5;
	localparam int SERIAL_PORT_CONTROL_REG_BUSY    = 6;
	localparam int SERIAL_PORT_CONTROL_REG_OVR     = 7;
	// data register fields
	localparam int DATA_VALID   = 8;
	// boot restart sequence
	localparam logic [7:0] SEQ_MARK = 8'h80;
	localparam logic [7:0] SEQ_MID  = 8'h24;
	localparam logic [1:0] SEQ_LAST = 2'h2;
	// frame lengths
	localparam logic [3:0] UART_BITS = 4'hA;
	localparam logic [3:0] SYNC_BITS = 4'h8;
	localparam logic [2:0] BIT_TOP   = 3'h7;
	typedef enum {PPB_IDLE, PPB_START, PPB_DATA, PPB_STOP} ppb_rx_t;
endpackage

// File: rtl/ppb_fifo.sv
// small ready/valid fifo for received bytes
`timescale 1ns/1ps
`default_nettype none
module ppb_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two, at least 2");
	end
	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ptr;
	logic [AW:0]  rd_ptr;
	wire          push = in_valid && in_ready;
	wire          pop  = out_valid && out_ready;

	assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	property p_fifo_full_blocks;
		@(posedge clk) disable iff (rst)
		(!in_ready && !pop) |=> !in_ready;
	endproperty
	a_fifo_full_blocks: assert property (p_fifo_full_blocks)
		else $error("fifo left full state without a pop");
endmodule
`default_nettype wire

// File: rtl/ppb_port.sv
// programming port boot link: apb slave, serial port, boot straps, gpio
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ppb_port #(
	parameter int BIT_CYCLES = ppb_pkg::BIT_CYCLES,
	parameter int FIFO_DEPTH = ppb_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        SRST,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// serial port pins
	input  wire logic        PORT_SERIAL_RECEIVE,
	output logic             PORT_SERIAL_TRANSMIT,
	input  wire logic        PORT_SERIAL_CLOCK_I,
	output logic             PORT_SERIAL_CLOCK_O,
	output logic             PORT_SERIAL_CLOCK_OE_N,
	output logic             RX_PULLUP_EN,
	output logic             CLK_PULLUP_EN,
	// boot and reset pins
	input  wire logic        BOOT_STRAP_LOW_BIT,
	input  wire logic        BOOT_STRAP_HIGH_BIT,
	input  wire logic        HOST_RESET_REQ,
	output logic             CPU_RESET,
	output logic             STATUS_OUT,
	output logic             BOOT_RESTART
);
	import ppb_pkg::*;
	localparam int CW = $clog2(BIT_CYCLES + 1);
	localparam logic [CW-1:0] BIT_LAST  = CW'(BIT_CYCLES - 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYCLES / 2 - 1);
	if (BIT_CYCLES < 4) begin : g_bad_bit
		$error("bit period must be at least 4 clocks");
	end

	////////////////////////////////////////////////////////////////////////
	// apb decode
	wire acc      = PSEL && PENABLE;
	wire done     = acc && PREADY;
	wire wr_en    = done && PWRITE;
	wire hit_ctrl = PADDR == ADDR_CTRL;
	wire hit_serial_port_control_reg = PADDR == ADDR_SERIAL_PORT_CONTROL_REG;
	wire hit_data = PADDR == ADDR_DATA;
	wire mapped   = hit_ctrl || hit_serial_port_control_reg || hit_data;

	logic          uart_en;
	logic          gpio_mode;
	logic          tx_gpio;
	logic          status_bit;
	logic          clocked;
	logic          cold_boot;
	logic          cable;
	logic          boot_seen;
	logic          overrun;
	logic          tx_busy;
	logic          rx_new;
	logic [7:0]    rx_byte;
	logic          pend;
	logic [7:0]    pend_data;
	logic          fifo_ready;
	logic          fifo_valid;
	logic [7:0]    fifo_data;
	logic          clk_prev;
	logic [1:0]    seq_cnt;
	wire           rd_pop = done && !PWRITE && hit_data;
	wire           clk_rise = PORT_SERIAL_CLOCK_I && !clk_prev;
	wire           clk_fall = !PORT_SERIAL_CLOCK_I && clk_prev;
	wire [31:0]    ctrl_rd = {26'h0, cold_boot, clocked, status_bit,
		tx_gpio, gpio_mode, uart_en};
	wire [31:0]    serial_port_control_reg_rd = {24'h0, overrun, tx_busy, fifo_valid, cable,
		PORT_SERIAL_CLOCK_I, PORT_SERIAL_RECEIVE,
		BOOT_STRAP_HIGH_BIT, BOOT_STRAP_LOW_BIT};
	wire [31:0]    data_rd = {23'h0, fifo_valid, fifo_data};

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			PREADY <= 1'b0;
		end else begin
			PREADY <= acc && !PREADY;
		end
	end
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			PRDATA  <= 32'h0;
			PSLVERR <= 1'b0;
		end else if (acc && !PREADY) begin
			PSLVERR <= !mapped;
			if (PWRITE) begin
				PRDATA <= 32'h0;
			end else if (hit_ctrl) begin
				PRDATA <= ctrl_rd;
			end else if (hit_serial_port_control_reg) begin
				PRDATA <= serial_port_control_reg_rd;
			end else if (hit_data) begin
				PRDATA <= data_rd;
			end else begin
				PRDATA <= 32'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register; general io use assumes programming is finished
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			uart_en    <= 1'b0;
			gpio_mode  <= 1'b0;
			tx_gpio    <= 1'b0;
			status_bit <= 1'b0;
			clocked    <= 1'b0;
		end else if (wr_en && hit_ctrl) begin
			uart_en    <= PWDATA[CTRL_UART_EN];
			gpio_mode  <= PWDATA[CTRL_GPIO];
			tx_gpio    <= PWDATA[CTRL_TX_GPIO];
			status_bit <= PWDATA[CTRL_STATUS];
			clocked    <= PWDATA[CTRL_CLOCKED];
		end
	end

	// straps are caught in the first cycle after reset release
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			boot_seen <= 1'b0;
			cable     <= 1'b0;
			cold_boot <= 1'b0;
		end else if (!boot_seen) begin
			boot_seen <= 1'b1;
			cable     <= BOOT_STRAP_LOW_BIT && BOOT_STRAP_HIGH_BIT;
			cold_boot <= BOOT_STRAP_LOW_BIT && BOOT_STRAP_HIGH_BIT;
		end else if (wr_en && hit_ctrl) begin
			// software may only end cold boot, never start it
			cold_boot <= cold_boot && PWDATA[CTRL_COLD];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receiver: uart at the bit rate, or shift on partner clock edges
	ppb_rx_t       rx_state;
	logic [CW-1:0] rx_cnt;
	logic [2:0]    rx_bit;
	logic [7:0]    rx_sh;

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			clk_prev <= 1'b1;
		end else begin
			clk_prev <= PORT_SERIAL_CLOCK_I;
		end
	end
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rx_state <= PPB_IDLE;
			rx_cnt   <= '0;
			rx_bit   <= 3'h0;
			rx_sh    <= 8'h00;
			rx_new   <= 1'b0;
			rx_byte  <= 8'h00;
		end else begin
			rx_new <= 1'b0;
			if (clocked) begin
				rx_state <= PPB_IDLE;
				if (clk_rise) begin
					rx_sh  <= {PORT_SERIAL_RECEIVE, rx_sh[7:1]};
					rx_bit <= rx_bit + 3'h1;
					if (rx_bit == BIT_TOP) begin
						rx_new  <= 1'b1;
						rx_byte <= {PORT_SERIAL_RECEIVE, rx_sh[7:1]};
					end
				end
			end else begin
				case (rx_state)
				PPB_IDLE: begin
					rx_bit <= 3'h0;
					if (!PORT_SERIAL_RECEIVE && (uart_en || cold_boot)) begin
						rx_cnt   <= HALF_LAST;
						rx_state <= PPB_START;
					end
				end
				PPB_START: begin
					if (rx_cnt != '0) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else if (PORT_SERIAL_RECEIVE) begin
						rx_state <= PPB_IDLE; // glitch, not a start bit
					end else begin
						rx_cnt   <= BIT_LAST;
						rx_state <= PPB_DATA;
					end
				end
				PPB_DATA: begin
					if (rx_cnt != '0) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else begin
						rx_cnt <= BIT_LAST;
						rx_sh  <= {PORT_SERIAL_RECEIVE, rx_sh[7:1]};
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == BIT_TOP) begin
							rx_state <= PPB_STOP;
						end
					end
				end
				PPB_STOP: begin
					if (rx_cnt != '0) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else begin
						// a bad stop bit drops the byte
						rx_new   <= PORT_SERIAL_RECEIVE;
						rx_byte  <= rx_sh;
						rx_state <= PPB_IDLE;
					end
				end
				default: rx_state <= PPB_IDLE;
				endcase
			end
		end
	end

	// one byte of slack ahead of the fifo; a second byte while stalled
	// is lost and flagged
	wire stall = pend && !fifo_ready;
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			pend      <= 1'b0;
			pend_data <= 8'h00;
		end else begin
			pend <= rx_new || stall;
			if (rx_new && !stall) begin
				pend_data <= rx_byte;
			end
		end
	end
	// set wins over the write-one clear
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			overrun <= 1'b0;
		end else if (rx_new && stall) begin
			overrun <= 1'b1;
		end else if (wr_en && hit_serial_port_control_reg && PWDATA[SERIAL_PORT_CONTROL_REG_OVR]) begin
			overrun <= 1'b0;
		end
	end

	ppb_fifo #(
		.W     (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (MCLK),
		.rst       (SRST),
		.in_valid  (pend),
		.in_ready  (fifo_ready),
		.in_data   (pend_data),
		.out_valid (fifo_valid),
		.out_ready (rd_pop),
		.out_data  (fifo_data)
	);

	// restart sequence watch, armed during cold boot
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			seq_cnt      <= 2'h0;
			BOOT_RESTART <= 1'b0;
		end else begin
			BOOT_RESTART <= 1'b0;
			if (rx_new && cold_boot) begin
				if (seq_cnt == SEQ_LAST && rx_byte == SEQ_MARK) begin
					BOOT_RESTART <= 1'b1;
					seq_cnt      <= 2'h0;
				end else if (seq_cnt == 2'h1 && rx_byte == SEQ_MID) begin
					seq_cnt <= SEQ_LAST;
				end else begin
					seq_cnt <= (rx_byte == SEQ_MARK) ? 2'h1 : 2'h0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmitter; writes while busy are dropped
	logic [CW-1:0] tx_cnt;
	logic [3:0]    tx_left;
	logic [9:0]    tx_frame;
	wire           tx_load = wr_en && hit_data && !tx_busy;
	wire           tx_line = tx_busy ? tx_frame[0] : 1'b1;

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tx_busy  <= 1'b0;
			tx_cnt   <= '0;
			tx_left  <= 4'h0;
			tx_frame <= 10'h3FF;
		end else if (tx_load) begin
			tx_busy <= 1'b1;
			tx_cnt  <= BIT_LAST;
			if (clocked) begin
				tx_frame <= {2'h3, PWDATA[7:0]};
				tx_left  <= SYNC_BITS;
			end else begin
				// bit rate matches the host's 2400 bps boot string
				tx_frame <= {1'b1, PWDATA[7:0], 1'b0};
				tx_left  <= UART_BITS;
			end
		end else if (tx_busy) begin
			if (clocked ? clk_fall : (tx_cnt == '0)) begin
				tx_cnt   <= BIT_LAST;
				tx_frame <= {1'b1, tx_frame[9:1]};
				tx_left  <= tx_left - 4'h1;
				tx_busy  <= tx_left != 4'h1;
			end else if (!clocked) begin
				tx_cnt <= tx_cnt - 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pins
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			PORT_SERIAL_TRANSMIT <= 1'b0;
		end else if (gpio_mode) begin
			PORT_SERIAL_TRANSMIT <= tx_gpio;
		end else if (cold_boot || uart_en || clocked) begin
			PORT_SERIAL_TRANSMIT <= tx_line;
		end else begin
			PORT_SERIAL_TRANSMIT <= 1'b0;
		end
	end
	// the clock line is only ever an input here, so it is never driven
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			PORT_SERIAL_CLOCK_O    <= 1'b0;
			PORT_SERIAL_CLOCK_OE_N <= 1'b1;
			RX_PULLUP_EN           <= 1'b1;
			CLK_PULLUP_EN          <= 1'b1;
		end else begin
			PORT_SERIAL_CLOCK_O    <= 1'b0;
			PORT_SERIAL_CLOCK_OE_N <= 1'b1;
			RX_PULLUP_EN           <= 1'b1;
			CLK_PULLUP_EN          <= 1'b1;
		end
	end
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			CPU_RESET  <= 1'b0;
			STATUS_OUT <= 1'b0;
		end else begin
			CPU_RESET  <= HOST_RESET_REQ;
			STATUS_OUT <= status_bit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);

	property p_reset_follow;
		HOST_RESET_REQ |=> CPU_RESET && STATUS_OUT == $past(status_bit);
	endproperty
	a_reset_follow: assert property (p_reset_follow)
		else $error("cpu reset did not follow host request");
	property p_restart;
		(rx_new && cold_boot && seq_cnt == SEQ_LAST && rx_byte == SEQ_MARK)
			|=> BOOT_RESTART ##1 !BOOT_RESTART;
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart sequence gave no single restart pulse");
	property p_cable;
		(!boot_seen && BOOT_STRAP_LOW_BIT && BOOT_STRAP_HIGH_BIT)
			|=> cable && cold_boot;
	endproperty
	a_cable: assert property (p_cable)
		else $error("straps high at boot not seen as cable");
	property p_poll;
		(pend && fifo_ready) |=> fifo_valid;
	endproperty
	a_poll: assert property (p_poll)
		else $error("received byte not visible to software");
	property p_pullup;
		$rose(boot_seen) |-> (RX_PULLUP_EN && CLK_PULLUP_EN) [*4];
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("pull-ups released");
	property p_clk_in;
		clocked && clk_rise && rx_bit == BIT_TOP |=> rx_new;
	endproperty
	a_clk_in: assert property (p_clk_in)
		else $error("clocked byte not completed after eight edges");
	property p_tx_low;
		(!gpio_mode && !cold_boot && !uart_en && !clocked)
			|=> !PORT_SERIAL_TRANSMIT;
	endproperty
	a_tx_low: assert property (p_tx_low)
		else $error("transmit not low without cold boot");
	property p_gpio_tx;
		gpio_mode |=> PORT_SERIAL_TRANSMIT == $past(tx_gpio);
	endproperty
	a_gpio_tx: assert property (p_gpio_tx)
		else $error("transmit does not follow general output bit");
	property p_strap_read;
		(acc && !PREADY && !PWRITE && hit_serial_port_control_reg) |=> PREADY
			&& PRDATA[SERIAL_PORT_CONTROL_REG_LO] == $past(BOOT_STRAP_LOW_BIT)
			&& PRDATA[SERIAL_PORT_CONTROL_REG_HI] == $past(BOOT_STRAP_HIGH_BIT);
	endproperty
	a_strap_read: assert property (p_strap_read)
		else $error("strap levels misread");
	property p_alt_read;
		(acc && !PREADY && !PWRITE && hit_serial_port_control_reg) |=>
			PRDATA[SERIAL_PORT_CONTROL_REG_RX] == $past(PORT_SERIAL_RECEIVE)
			&& PRDATA[SERIAL_PORT_CONTROL_REG_CLK] == $past(PORT_SERIAL_CLOCK_I);
	endproperty
	a_alt_read: assert property (p_alt_read)
		else $error("alternate input levels misread");

	c_restart: cover property (BOOT_RESTART);
	c_cable:   cover property (boot_seen && cable);
	c_overrun: cover property (rx_new && stall);
	c_pop:     cover property (rd_pop && fifo_valid);
endmodule
`default_nettype wire

// File: tb/ppb_host_model.sv
// host side of the programming cable: uart bytes, reset request, straps
`timescale 1ns/1ps
`default_nettype none
module ppb_host_model #(
	parameter int BIT_CYCLES = 8
) (
	// clock
	input  wire logic clk,
	// lines seen through the cable
	input  wire logic transmit,
	output logic      receive,
	output logic      serial_clock,
	output logic      strap_lo,
	output logic      strap_hi,
	output logic      reset_req
);
	logic lo_lvl = 1'b0;
	logic loop_tx = 1'b0;
	initial begin
		receive = 1'b1;
		// the pulled-up clock line idles high between clocked bytes
		serial_clock = 1'b1;
		strap_hi = 1'b0;
		reset_req = 1'b0;
	end
	// a looping cable ties transmit back onto the low strap
	assign strap_lo = loop_tx ? transmit : lo_lvl;
	////////////////////////////////////////////////////////////////////////
	task automatic set_straps(input logic lo, input logic hi);
		lo_lvl <= lo;
		strap_hi <= hi;
	endtask
	task automatic set_loop(input logic on);
		loop_tx <= on;
	endtask
	task automatic set_reset(input logic v);
		reset_req <= v;
	endtask
	// restart: reset pulse, then a short pause; the caller sends the string at the baud rate
	task automatic pulse_reset();
		set_reset(1'b1);
		repeat (4) @(posedge clk);
		set_reset(1'b0);
		repeat (8) @(posedge clk);
	endtask
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			receive <= fr[i];
			repeat (BIT_CYCLES - 1) @(posedge clk);
		end
	endtask
	task automatic recv_byte(output logic [7:0] b, output logic stp);
		int n;
		n = 0;
		b = 8'h00;
		while (transmit !== 1'b0 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		repeat (BIT_CYCLES / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clk);
			b[i] = transmit;
		end
		repeat (BIT_CYCLES) @(posedge clk);
		stp = transmit;
	endtask
	// clocked partner: take the transmit bit, then lower the clock with
	// new data; the device shifts in on the following rising edge
	task automatic clocked_byte(input logic [7:0] o, output logic [7:0] b);
		repeat (2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			b[i] = transmit;
			serial_clock <= 1'b0;
			receive <= o[i];
			repeat (4) @(posedge clk);
			serial_clock <= 1'b1;
			repeat (3) @(posedge clk);
		end
		receive <= 1'b1;
	endtask
endmodule
`default_nettype wire

// File: tb/tb_ppb_port.sv
// self-checking bench for the programming port boot link
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	fails++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_ppb_port;
	import ppb_pkg::*;
	localparam int BC = 8;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, txd, clk_o, clk_oe_n, rx_pu, clk_pu;
	logic        hrx, hclk, hlo, hhi, hrst, cpu_rst, status, restart;
	int          fails = 0;
	int          check_count = 0;
	int          restarts = 0;
	int          seen;
	logic [31:0] rdata;
	logic        rerr, stopb;
	logic [7:0]  rb;
	logic [7:0]  q [5] = '{8'h80, 8'h24, 8'h80, 8'h11, 8'h22};
	always #5 mclk = ~mclk;
	always @(posedge mclk) if (restart === 1'b1) restarts++;
	ppb_port #(.BIT_CYCLES(BC), .FIFO_DEPTH(FIFO_DEPTH)) dut (
		.MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .PORT_SERIAL_RECEIVE(hrx),
		.PORT_SERIAL_TRANSMIT(txd), .PORT_SERIAL_CLOCK_I(hclk),
		.PORT_SERIAL_CLOCK_O(clk_o), .PORT_SERIAL_CLOCK_OE_N(clk_oe_n),
		.RX_PULLUP_EN(rx_pu), .CLK_PULLUP_EN(clk_pu),
		.BOOT_STRAP_LOW_BIT(hlo), .BOOT_STRAP_HIGH_BIT(hhi),
		.HOST_RESET_REQ(hrst), .CPU_RESET(cpu_rst), .STATUS_OUT(status),
		.BOOT_RESTART(restart));
	ppb_host_model #(.BIT_CYCLES(BC)) host (
		.clk(mclk), .transmit(txd), .receive(hrx), .serial_clock(hclk),
		.strap_lo(hlo), .strap_hi(hhi), .reset_req(hrst));
	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		`CHK("pready", 1'b1, pready)
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic do_reset();
		@(posedge mclk);
		srst <= 1'b1;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		tally_and_finish();
	end
	initial begin
		do_reset();
		`CHK("transmit", 1'b0, txd)
		`CHK("rx pullup", 1'b1, rx_pu)
		`CHK("clk pullup", 1'b1, clk_pu)
		`CHK("clk oe_n", 1'b1, clk_oe_n)
		`CHK("clk out", 1'b0, clk_o)
		rd(ADDR_SERIAL_PORT_CONTROL_REG);
		`CHK("serial_port_control_reg", 8'h0C, rdata[7:0])
		rd(12'h00C);
		`CHK("slverr", 1'b1, rerr)
		for (int i = 0; i < 4; i++) begin
			host.set_straps(i[0], i[1]);
			rd(ADDR_SERIAL_PORT_CONTROL_REG);
			`CHK("straps", i[1:0], rdata[1:0])
		end
		host.set_reset(1'b1);
		@(posedge mclk);
		`CHK("cpu reset lag", 1'b0, cpu_rst)
		@(posedge mclk);
		`CHK("cpu reset", 1'b1, cpu_rst)
		host.set_reset(1'b0);
		wr(ADDR_CTRL, 32'h08);
		repeat (3) @(posedge mclk);
		`CHK("status", 1'b1, status)
		wr(ADDR_CTRL, 32'h20);
		repeat (3) @(posedge mclk);
		`CHK("status off", 1'b0, status)
		rd(ADDR_CTRL);
		`CHK("cold set", 1'b0, rdata[5])
		$display("test pins done");
		host.set_straps(1'b0, 1'b0);
		wr(ADDR_CTRL, 32'h01);
		seen = restarts;
		foreach (q[i]) host.send_byte(q[i]);
		rd(ADDR_SERIAL_PORT_CONTROL_REG);
		`CHK("avail", 2'b01, {rdata[7], rdata[5]})
		host.send_byte(8'h33);
		repeat (4) @(posedge mclk);
		rd(ADDR_SERIAL_PORT_CONTROL_REG);
		`CHK("overrun", 1'b1, rdata[7])
		wr(ADDR_SERIAL_PORT_CONTROL_REG, 32'h80);
		rd(ADDR_SERIAL_PORT_CONTROL_REG);
		`CHK("overrun clr", 1'b0, rdata[7])
		foreach (q[i]) begin
			rd(ADDR_DATA);
			`CHK("rx byte", {1'b1, q[i]}, rdata[8:0])
		end
		rd(ADDR_DATA);
		`CHK("rx empty", 1'b0, rdata[8])
		`CHK("no restart", seen, restarts)
		fork
			wr(ADDR_DATA, 32'h5A);
			host.recv_byte(rb, stopb);
		join
		`CHK("tx byte", {1'b1, 8'h5A}, {stopb, rb})
		$display("test uart done");
		host.set_straps(1'b1, 1'b1);
		do_reset();
		rd(ADDR_SERIAL_PORT_CONTROL_REG);
		`CHK("cable", 8'h1F, rdata[7:0])
		rd(ADDR_CTRL);
		`CHK("cold", 1'b1, rdata[5])
		`CHK("tx idle", 1'b1, txd)
		host.pulse_reset();
		seen = restarts;
		for (int i = 0; i < 3; i++) host.send_byte(q[i]);
		repeat (4) @(posedge mclk);
		`CHK("restart", seen + 1, restarts)
		$display("test cold boot done");
		host.set_loop(1'b1);
		wr(ADDR_CTRL, 32'h06);
		repeat (3) @(posedge mclk);
		rd(ADDR_SERIAL_PORT_CONTROL_REG);
		`CHK("loop high", 1'b1, rdata[0])
		rd(ADDR_CTRL);
		`CHK("ctrl", 6'h06, rdata[5:0])
		wr(ADDR_CTRL, 32'h02);
		repeat (3) @(posedge mclk);
		rd(ADDR_SERIAL_PORT_CONTROL_REG);
		`CHK("loop low", 1'b0, rdata[0])
		`CHK("gpio tx", 1'b0, txd)
		host.set_loop(1'b0);
		$display("test cable done");
		for (int i = 0; i < 3; i++) begin
			rd(ADDR_DATA);
			`CHK("boot byte", {1'b1, q[i]}, rdata[8:0])
		end
		wr(ADDR_CTRL, 32'h10);
		wr(ADDR_DATA, 32'hA5);
		host.clocked_byte(8'h3C, rb);
		`CHK("sync tx", 8'hA5, rb)
		rd(ADDR_DATA);
		`CHK("sync rx", {1'b1, 8'h3C}, rdata[8:0])
		rd(ADDR_SERIAL_PORT_CONTROL_REG);
		`CHK("sync idle", 1'b0, rdata[6])
		$display("test clocked done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
